// ---- verilog/rsc_pkg.sv ----
// Constants, register map and state codes for the reset source controller.
package rsc_pkg;

  // Clock rate and start-up delay times.
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned TOUT_FAST_NS   = 150;
  localparam int unsigned TOUT_MID_US    = 4100;
  localparam int unsigned TOUT_LONG_US   = 65000;
  localparam int unsigned TOUT_XTAL_US   = 1000;
  localparam int unsigned TOUT_FAST_CYC  = (TOUT_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TOUT_MID_CYC   = TOUT_MID_US * CLK_MHZ;
  localparam int unsigned TOUT_LONG_CYC  = TOUT_LONG_US * CLK_MHZ;
  localparam int unsigned TOUT_XTAL_CYC  = TOUT_XTAL_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 24;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_CTRL       = 8'h04;
  localparam logic [7:0] ADDR_STATE      = 8'h08;

  // Reset cause status fields.
  localparam int unsigned BIT_SUPPLY_UP  = 0;
  localparam int unsigned BIT_PIN        = 1;
  localparam int unsigned BIT_LOW_SUPPLY = 2;
  localparam int unsigned BIT_TIMEOUT    = 3;
  localparam int unsigned BIT_BUS        = 5;
  localparam logic [7:0] STATUS_MASK     = 8'h2F;
  localparam logic [7:0] POR_CLR_MASK    = 8'h2E;
  localparam logic [7:0] STATUS_RESET    = 8'h00;

  // Control register fields.
  localparam int unsigned CTRL_BG_BIT    = 0;
  localparam int unsigned CTRL_WDM_LSB   = 1;
  localparam logic [7:0] CTRL_MASK       = 8'h07;
  localparam logic [7:0] CTRL_RESET      = 8'h04;

  // Source vector positions after synchronisation.
  localparam int unsigned SRC_POR        = 0;
  localparam int unsigned SRC_PIN        = 1;
  localparam int unsigned SRC_LOW        = 2;
  localparam int unsigned SRC_TMO        = 3;
  localparam int unsigned SRC_BUS        = 4;
  localparam int unsigned SRC_N          = 5;

  localparam logic [2:0] LVL_OFF         = 3'b111;

  typedef enum logic [1:0] {
    WDM_OFF  = 2'b00,
    WDM_IRQ  = 2'b01,
    WDM_RST  = 2'b10,
    WDM_BOTH = 2'b11
  } rsc_wdm_t;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN   = 2'b10
  } rsc_state_t;

endpackage : rsc_pkg

// ---- verilog/rsc_ctrl.sv ----
// Reset source controller: cause gathering, start-up delay, cause flags and bandgap enable.
`timescale 1ns/1ps
module rsc_ctrl
  import rsc_pkg::*;
#(
  parameter int unsigned TOUT_MID_P  = TOUT_MID_CYC,
  parameter int unsigned TOUT_LONG_P = TOUT_LONG_CYC,
  parameter int unsigned TOUT_XTAL_P = TOUT_XTAL_CYC
) (
  // Clock and block reset.
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Reset causes.
  input  wire logic        supply_below_in,
  input  wire logic        pin_reset_n_in,
  input  wire logic        low_supply_below_in,
  input  wire logic        timeout_expire_in,
  input  wire logic        bus_reset_det_in,
  // Configuration settings.
  input  wire logic [2:0]  low_supply_level_sel_in,
  input  wire logic [1:0]  startup_time_sel_in,
  input  wire logic [3:0]  clock_source_sel_in,
  input  wire logic        bus_macro_en_in,
  input  wire logic        bus_reset_core_en_in,
  // Wishbone slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Reset and analog controls.
  output logic             core_reset_out,
  output logic             io_reset_out,
  output logic             bus_macro_reset_out,
  output logic             timeout_irq_out,
  output logic             bandgap_en_out,
  output logic             low_supply_detector_en_out,
  output logic      [2:0]  low_supply_level_out
);

  logic [SRC_N-1:0] sync1_ff;
  logic [SRC_N-1:0] sync2_ff;
  logic             tmo_prev_ff;
  logic             tmo_pulse_ff;
  logic             tmo_armed_ff;
  logic             irq_ff;
  rsc_state_t       state_ff;
  rsc_state_t       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             core_reset_ff;
  logic             io_reset_ff;
  logic             bus_rst_ff;
  logic [7:0]       flags_ff;
  logic [7:0]       nxt_flags;
  logic [7:0]       ctrl_ff;
  logic             bg_ff;
  logic             det_en_ff;
  logic [2:0]       level_ff;
  logic             ack_ff;
  logic [31:0]      rdat_ff;

  // Asynchronous path: these sources force the reset flops without any clock edge.
  wire              det_en      = (low_supply_level_sel_in != LVL_OFF);
  wire              async_src_n = pin_reset_n_in & ~supply_below_in & ~(det_en & low_supply_below_in);
  wire              hold_rst_n  = rst_n_in & async_src_n;
  wire [SRC_N-1:0]  raw_src     = {bus_reset_det_in, timeout_expire_in, low_supply_below_in,
                                   ~pin_reset_n_in, supply_below_in};

  // Synchronised causes for the clocked logic.
  wire              por_s  = sync2_ff[SRC_POR];
  wire              pin_s  = sync2_ff[SRC_PIN];
  wire              low_s  = sync2_ff[SRC_LOW] & det_en;
  wire              bus_s  = sync2_ff[SRC_BUS] & bus_macro_en_in & bus_reset_core_en_in;
  wire              tmo_edge = sync2_ff[SRC_TMO] & ~tmo_prev_ff;
  wire              other_src = por_s | pin_s | low_s | tmo_pulse_ff;
  wire              any_src   = other_src | bus_s;

  // Watchdog mode; the time base itself lives on the watchdog's own oscillator.
  wire rsc_wdm_t    wdm      = rsc_wdm_t'(ctrl_ff[CTRL_WDM_LSB +: 2]);
  wire              tmo_rst  = tmo_edge & ((wdm == WDM_RST) | ((wdm == WDM_BOTH) & tmo_armed_ff));
  wire              tmo_irq  = tmo_edge & ((wdm == WDM_IRQ) | ((wdm == WDM_BOTH) & ~tmo_armed_ff));

  // Delay length from start-up and clock source selections.
  wire [CNT_W-1:0]  base_cyc = (startup_time_sel_in == 2'b00) ? CNT_W'(TOUT_FAST_CYC) :
                               (startup_time_sel_in == 2'b01) ? CNT_W'(TOUT_MID_P) :
                               CNT_W'(TOUT_LONG_P);
  wire [CNT_W-1:0]  xtal_cyc = clock_source_sel_in[0] ? CNT_W'(TOUT_XTAL_P) : '0;
  wire [CNT_W-1:0]  load_cyc = CNT_W'(base_cyc + xtal_cyc);

  // Bus decode.
  wire              wb_req   = wb_cyc_in & wb_stb_in;
  wire              wb_take  = wb_req & ~ack_ff;
  // Writes land on the edge at which the master sees ack, while its request still stands.
  wire              wr_lane0 = wb_req & ack_ff & wb_we_in & wb_sel_in[0];
  wire              hit_stat = (wb_adr_in == ADDR_STATUS);
  wire              hit_ctrl = (wb_adr_in == ADDR_CTRL);
  wire              hit_st   = (wb_adr_in == ADDR_STATE);
  wire              wr_stat  = wr_lane0 & hit_stat;
  wire              wr_ctrl  = wr_lane0 & hit_ctrl;
  wire [7:0]        state_rd = {3'b000, tmo_armed_ff, bus_rst_ff, core_reset_ff, state_ff};
  wire [7:0]        rd_byte  = hit_stat ? (flags_ff & STATUS_MASK) :
                               hit_ctrl ? (ctrl_ff & CTRL_MASK) :
                               hit_st   ? state_rd : 8'h00;

  // Flags: a hardware set beats a software clear; power-on clears the other causes.
  wire [7:0]        set_vec  = {2'b00, bus_s, 1'b0, tmo_pulse_ff, low_s, pin_s, por_s};
  wire [7:0]        sw_clr   = wr_stat ? ~wb_dat_in[7:0] : 8'h00;
  wire [7:0]        por_clr  = por_s ? POR_CLR_MASK : 8'h00;
  assign nxt_flags = (((flags_ff & ~sw_clr) | set_vec) & ~por_clr) & STATUS_MASK;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw_src;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmo_prev_ff  <= 1'b0;
      tmo_pulse_ff <= 1'b0;
      irq_ff       <= 1'b0;
    end else begin
      tmo_prev_ff  <= sync2_ff[SRC_TMO];
      tmo_pulse_ff <= tmo_rst;
      irq_ff       <= tmo_irq;
    end
  end

  // In the combined mode the first expiry interrupts and the next one resets.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmo_armed_ff <= 1'b0;
    end else if (wr_ctrl || core_reset_ff) begin
      tmo_armed_ff <= 1'b0;
    end else if (tmo_irq && wdm == WDM_BOTH) begin
      tmo_armed_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_HOLD: begin
        nxt_cnt = load_cyc;
        if (!any_src) begin
          nxt_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (any_src) begin
          nxt_state = ST_HOLD;
        end else if (cnt_ff == '0) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          nxt_state = ST_HOLD;
        end
      end
      default: begin
        nxt_state = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_HOLD;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Reset outputs assert with no clock when an asynchronous cause is present.
  always_ff @(posedge ref_clk_in or negedge hold_rst_n) begin
    if (!hold_rst_n) begin
      core_reset_ff <= 1'b1;
      io_reset_ff   <= 1'b1;
      bus_rst_ff    <= 1'b1;
    end else begin
      core_reset_ff <= (nxt_state != ST_RUN);
      io_reset_ff   <= any_src;
      bus_rst_ff    <= other_src;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_ff <= STATUS_RESET;
      ctrl_ff  <= CTRL_RESET;
    end else begin
      flags_ff <= nxt_flags;
      if (wr_ctrl) begin
        ctrl_ff <= wb_dat_in[7:0] & CTRL_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bg_ff     <= 1'b0;
      det_en_ff <= 1'b0;
      level_ff  <= LVL_OFF;
    end else begin
      bg_ff     <= det_en | ctrl_ff[CTRL_BG_BIT];
      det_en_ff <= det_en;
      level_ff  <= low_supply_level_sel_in;
    end
  end

  // The answer comes one cycle after the request; ack drops the cycle after.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff <= wb_take;
      if (wb_take) begin
        rdat_ff <= {24'h000000, rd_byte};
      end
    end
  end

  assign wb_dat_out                 = rdat_ff;
  assign wb_ack_out                 = ack_ff;
  assign core_reset_out             = core_reset_ff;
  assign io_reset_out               = io_reset_ff;
  assign bus_macro_reset_out        = bus_rst_ff;
  assign timeout_irq_out            = irq_ff;
  assign bandgap_en_out             = bg_ff;
  assign low_supply_detector_en_out = det_en_ff;
  assign low_supply_level_out       = level_ff;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_por_hold;
    por_s |=> core_reset_out ##1 core_reset_out;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("Reset not held during power-on cause.");

  property p_release;
    $fell(core_reset_ff) |-> $past(state_ff) == ST_COUNT && $past(cnt_ff) == '0;
  endproperty
  a_release: assert property (p_release) else $error("Core released before delay expiry.");

  property p_pin;
    pin_s |=> core_reset_out && io_reset_out;
  endproperty
  a_pin: assert property (p_pin) else $error("Pin reset did not hold the core.");

  property p_pin_stretch;
    $fell(pin_s) && !any_src |=> state_ff == ST_COUNT && core_reset_out;
  endproperty
  a_pin_stretch: assert property (p_pin_stretch) else $error("Pin release skipped the delay.");

  property p_low;
    low_s |=> core_reset_out && state_ff == ST_HOLD;
  endproperty
  a_low: assert property (p_low) else $error("Low supply did not assert reset.");

  property p_low_stretch;
    $fell(low_s) && !any_src |=> state_ff == ST_COUNT;
  endproperty
  a_low_stretch: assert property (p_low_stretch) else $error("Low supply release skipped the delay.");

  property p_level_off;
    low_supply_level_sel_in == LVL_OFF |-> !low_s ##1 !low_supply_detector_en_out;
  endproperty
  a_level_off: assert property (p_level_off) else $error("Detector enabled with level code off.");

  property p_tmo_one;
    $rose(tmo_pulse_ff) |=> !tmo_pulse_ff;
  endproperty
  a_tmo_one: assert property (p_tmo_one) else $error("Watchdog reset pulse longer than one cycle.");

  property p_tmo_count;
    tmo_pulse_ff ##1 !any_src |=> state_ff == ST_COUNT && cnt_ff == load_cyc;
  endproperty
  a_tmo_count: assert property (p_tmo_count) else $error("Delay did not start after watchdog pulse.");

  property p_bus_keep;
    bus_s && !other_src |=> core_reset_out && !bus_macro_reset_out;
  endproperty
  a_bus_keep: assert property (p_bus_keep) else $error("Bus reset wrongly reset the bus macro.");

  property p_bus_flag;
    bus_s && !por_s |=> flags_ff[BIT_BUS];
  endproperty
  a_bus_flag: assert property (p_bus_flag) else $error("Bus reset flag not set.");

  property p_tmo_flag;
    tmo_pulse_ff && !por_s |=> flags_ff[BIT_TIMEOUT];
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) else $error("Watchdog flag not set.");

  property p_low_flag;
    low_s && !por_s |=> flags_ff[BIT_LOW_SUPPLY];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("Low-supply flag not set.");

  property p_pin_flag;
    pin_s && !por_s |=> flags_ff[BIT_PIN];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("Pin flag not set.");

  property p_por_flag;
    por_s |=> flags_ff[BIT_SUPPLY_UP] && (flags_ff & POR_CLR_MASK) == 8'h00;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("Power-on flag handling wrong.");

  property p_reserved;
    wb_ack_out && $past(hit_stat) |-> wb_dat_out[7:6] == 2'b00 && !wb_dat_out[4];
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved status bits read non-zero.");

  property p_bandgap;
    (det_en || ctrl_ff[CTRL_BG_BIT]) ##1 (det_en || ctrl_ff[CTRL_BG_BIT]) |-> bandgap_en_out;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("Bandgap off while needed.");

  property p_tmo_irq;
    tmo_edge && wdm == WDM_IRQ |=> timeout_irq_out && !tmo_pulse_ff;
  endproperty
  a_tmo_irq: assert property (p_tmo_irq) else $error("Interrupt-only mode misbehaved.");

  property p_io;
    any_src |=> io_reset_out;
  endproperty
  a_io: assert property (p_io) else $error("I/O reset not asserted for active source.");

  property p_run_clean;
    state_ff == ST_RUN && $past(state_ff) == ST_RUN && $past(hold_rst_n) && hold_rst_n |-> !core_reset_out;
  endproperty
  a_run_clean: assert property (p_run_clean) else $error("Core held while running.");

  property p_multi;
    flags_ff[BIT_PIN] && !wr_stat && !por_s |=> flags_ff[BIT_PIN];
  endproperty
  a_multi: assert property (p_multi) else $error("Cause flag lost without clear.");

  c_tmo_release: cover property (tmo_pulse_ff ##[1:20] $fell(core_reset_ff));
  c_bus_reset: cover property (bus_s && !other_src ##1 core_reset_out);
  c_multi_flags: cover property (flags_ff[BIT_PIN] && flags_ff[BIT_TIMEOUT]);
  c_sw_clear: cover property (wr_stat ##1 flags_ff == 8'h00);

endmodule : rsc_ctrl

// ---- sim/rsc_cause_model.sv ----
// Far-side model: supply monitors, reset pin, watchdog on its own oscillator and the bus macro.
`timescale 1ns/1ps
module rsc_cause_model (
  // Requests from the bench.
  input  wire logic por_req_in,
  input  wire logic pin_req_in,
  input  wire logic low_req_in,
  input  wire logic wd_req_in,
  input  wire logic bus_req_in,
  // Cause lines towards the block.
  output logic      supply_below_out,
  output logic      pin_reset_n_out,
  output logic      low_supply_below_out,
  output logic      timeout_expire_out,
  output logic      bus_reset_det_out
);
  logic wd_osc    = 1'b0;
  logic expire_ff = 1'b0;

  assign supply_below_out     = por_req_in;
  assign pin_reset_n_out      = ~pin_req_in;
  assign low_supply_below_out = low_req_in;
  assign bus_reset_det_out    = bus_req_in;
  assign timeout_expire_out   = expire_ff;

  // The slow oscillator has no phase relation to the system clock, so expiry edges land anywhere.
  always #150.7 wd_osc = ~wd_osc;

  always @(posedge wd_osc) begin
    expire_ff <= wd_req_in;
  end
endmodule : rsc_cause_model

// ---- sim/rsc_ctrl_tb.sv ----
// Self-checking bench for the reset source controller.
`timescale 1ns/1ps
module rsc_ctrl_tb;
  import rsc_pkg::*;
  localparam int unsigned MID = 20;
  localparam int unsigned LNG = 40;
  localparam int unsigned XTL = 10;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        por_req = 1'b1;
  logic        pin_req = 1'b0;
  logic        low_req = 1'b0;
  logic        wd_req  = 1'b0;
  logic        bus_req = 1'b0;
  logic        sup_b, pin_n, low_b, expire, bus_det;
  logic [2:0]  lvl_sel = 3'h6;
  logic [1:0]  sut_sel = 2'h0;
  logic [3:0]  cks_sel = 4'h0;
  logic        bus_en  = 1'b0;
  logic        bus_cen = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic [3:0]  sel     = 4'h0;
  logic [3:0]  wsel    = 4'hF;
  logic [31:0] rdat;
  logic        ack, core_rst, io_rst, bus_rst, irq, bg_en, det_en, core_prev;
  logic [2:0]  lvl_out;
  logic [7:0]  exp_q[$];
  int          err_count = 0;
  int          checked   = 0;
  int          irq_cnt   = 0;
  int          core_rise = 0;
  int          n, n0, dly;
  int          seed      = 32'hEDBDF029;

  always #12.5 ref_clk = ~ref_clk;

  rsc_ctrl #(.TOUT_MID_P(MID), .TOUT_LONG_P(LNG), .TOUT_XTAL_P(XTL)) rsc_ctrl_inst (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .supply_below_in(sup_b), .pin_reset_n_in(pin_n),
    .low_supply_below_in(low_b), .timeout_expire_in(expire), .bus_reset_det_in(bus_det),
    .low_supply_level_sel_in(lvl_sel), .startup_time_sel_in(sut_sel), .clock_source_sel_in(cks_sel),
    .bus_macro_en_in(bus_en), .bus_reset_core_en_in(bus_cen), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .core_reset_out(core_rst), .io_reset_out(io_rst), .bus_macro_reset_out(bus_rst),
    .timeout_irq_out(irq), .bandgap_en_out(bg_en), .low_supply_detector_en_out(det_en),
    .low_supply_level_out(lvl_out));

  rsc_cause_model rsc_cause_model_inst (
    .por_req_in(por_req), .pin_req_in(pin_req), .low_req_in(low_req), .wd_req_in(wd_req),
    .bus_req_in(bus_req), .supply_below_out(sup_b), .pin_reset_n_out(pin_n),
    .low_supply_below_out(low_b), .timeout_expire_out(expire), .bus_reset_det_out(bus_det));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk(input logic b, input logic e);
    cmp({31'h0, b}, {31'h0, e});
  endtask : chk

  // Read data is judged by the watcher below, oldest expectation first.
  always @(posedge ref_clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (core_rst === 1'b1 && core_prev === 1'b0) core_rise <= core_rise + 1;
    core_prev <= core_rst;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) cmp(rdat, {24'h0, exp_q.pop_front()});
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'($random(seed)), d};
    sel  <= wsel;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask : rd

  // Two sync edges, the load edge and the expiry edge come on top of the d counted cycles.
  task automatic wait_rel(input int d);
    repeat (d - 1) @(posedge ref_clk);
    chk(core_rst, 1'b1);
    repeat (5) @(posedge ref_clk);
    chk(core_rst, 1'b1);
    @(posedge ref_clk);
    chk(core_rst, 1'b0);
  endtask : wait_rel

  task automatic fire();
    wd_req <= 1'b1;
    repeat (30) @(posedge ref_clk);
    wd_req <= 1'b0;
    repeat (60) @(posedge ref_clk);
  endtask : fire

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #500000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    por_req <= 1'b0;
    wait_rel(6);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_STATE, 8'h02);
    wb(1'b1, 8'h0C, 8'($random(seed)));
    rd(8'h0C, 8'h00);
    rd(ADDR_STATUS, 8'h01);
    for (int i = 0; i < 4; i++) begin
      sut_sel <= 2'(i);
      cks_sel <= 4'(i % 2);
      dly = (i == 0) ? 6 : ((i == 1) ? MID : LNG);
      dly = dly + ((i % 2 == 1) ? XTL : 0);
      @(posedge ref_clk);
      pin_req <= 1'b1;
      #2;
      chk(core_rst, 1'b1);
      chk(io_rst, 1'b1);
      repeat (5) @(posedge ref_clk);
      chk(bus_rst, 1'b1);
      pin_req <= 1'b0;
      wait_rel(dly);
    end
    sut_sel <= 2'h0;
    cks_sel <= 4'h0;
    rd(ADDR_STATUS, 8'h03);
    wb(1'b1, ADDR_STATUS, 8'hFE);
    rd(ADDR_STATUS, 8'h02);
    wb(1'b1, ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h02);
    wsel = 4'hE;
    wb(1'b1, ADDR_STATUS, 8'h00);
    wsel = 4'hF;
    rd(ADDR_STATUS, 8'h02);
    low_req <= 1'b1;
    #2;
    chk(core_rst, 1'b1);
    repeat (5) @(posedge ref_clk);
    low_req <= 1'b0;
    wait_rel(6);
    rd(ADDR_STATUS, 8'h06);
    for (int i = 0; i < 8; i++) begin
      lvl_sel <= 3'(i);
      repeat (3) @(posedge ref_clk);
      chk(det_en, i != 7);
      chk(bg_en, i != 7);
      cmp(32'(lvl_out), 32'(i));
    end
    n0 = core_rise;
    low_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    low_req <= 1'b0;
    chk(core_rst, 1'b0);
    cmp(32'(core_rise), 32'(n0));
    wb(1'b1, ADDR_CTRL, 8'h05);
    repeat (2) @(posedge ref_clk);
    chk(bg_en, 1'b1);
    wb(1'b1, ADDR_CTRL, 8'h04);
    repeat (2) @(posedge ref_clk);
    chk(bg_en, 1'b0);
    lvl_sel <= 3'h6;
    fire();
    cmp(32'(core_rise), 32'(n0 + 1));
    chk(core_rst, 1'b0);
    cmp(32'(irq_cnt), 32'd0);
    rd(ADDR_STATUS, 8'h0E);
    wb(1'b1, ADDR_CTRL, 8'h02);
    fire();
    cmp(32'(irq_cnt), 32'd1);
    wb(1'b1, ADDR_CTRL, 8'h06);
    fire();
    cmp(32'(irq_cnt), 32'd2);
    cmp(32'(core_rise), 32'(n0 + 1));
    rd(ADDR_STATE, 8'h12);
    fire();
    cmp(32'(core_rise), 32'(n0 + 2));
    wb(1'b1, ADDR_CTRL, 8'h04);
    bus_en  <= 1'b1;
    bus_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(core_rst, 1'b0);
    bus_req <= 1'b0;
    repeat (5) @(posedge ref_clk);
    bus_cen <= 1'b1;
    bus_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(core_rst, 1'b1);
    chk(bus_rst, 1'b0);
    bus_req <= 1'b0;
    wait_rel(6);
    rd(ADDR_STATUS, 8'h2E);
    por_req <= 1'b1;
    #2;
    chk(core_rst, 1'b1);
    repeat (5) @(posedge ref_clk);
    por_req <= 1'b0;
    wait_rel(6);
    rd(ADDR_STATUS, 8'h01);
    wb(1'b1, ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    end_of_test();
  end
endmodule : rsc_ctrl_tb
